// File: hw/mtfs_pkg.sv
// Shared constants and carrier types for the MAC transmit/flow/speed registers
package mtfs_pkg;

   // Register offsets on the management interface
   localparam logic [11:0] TX_CFG_OFFSET = 12'h408;
   localparam logic [11:0] FC_CFG_OFFSET = 12'h40c;
   localparam logic [11:0] SPEED_OFFSET  = 12'h410;

   // Transmitter control word field positions
   localparam int unsigned TX_RESET_BIT = 31;
   localparam int unsigned TX_JUMBO_BIT = 30;
   localparam int unsigned TX_FCS_BIT   = 29;
   localparam int unsigned TX_EN_BIT    = 28;
   localparam int unsigned TX_VLAN_BIT  = 27;
   localparam int unsigned TX_HD_BIT    = 26;
   localparam int unsigned TX_IFG_BIT   = 25;

   // Flow-control word field positions
   localparam int unsigned FC_TX_BIT = 30;
   localparam int unsigned FC_RX_BIT = 29;

   // Speed word field position (two bits, upper at SPEED_LSB+1)
   localparam int unsigned SPEED_LSB = 30;

   // Reset values
   localparam logic TX_JUMBO_RST = 1'h0;
   localparam logic TX_FCS_RST   = 1'h0;
   localparam logic TX_EN_RST    = 1'h1;
   localparam logic TX_VLAN_RST  = 1'h0;
   localparam logic TX_HD_RST    = 1'h0;
   localparam logic TX_IFG_RST   = 1'h0;
   localparam logic FC_TX_RST    = 1'h1;
   localparam logic FC_RX_RST    = 1'h1;

   // Speed codes
   localparam logic [1:0] SPEED_10M  = 2'h0;
   localparam logic [1:0] SPEED_100M = 2'h1;
   localparam logic [1:0] SPEED_1G   = 2'h2;
   localparam logic [1:0] SPEED_RST  = 2'h2;
   localparam logic [1:0] SPEED_LOW_RST = 2'h1;

   // Timing and length figures
   localparam logic [7:0]  IFG_MIN_CYCLES = 8'h0c;
   localparam logic [15:0] MAX_STD_LEN    = 16'h05ee;
   localparam logic [15:0] MAX_VLAN_LEN   = 16'h05f2;

   // Speed support chosen when the device is built
   typedef enum logic [1:0] {
      BUILD_TRI,
      BUILD_GIG,
      BUILD_LOW
   } mtfs_build_type;

   // One management request
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } mtfs_mgmt_req_type;

   // Stored transmitter configuration
   typedef struct packed {
      logic jumbo;
      logic fcsFromClient;
      logic enable;
      logic vlan;
      logic halfDuplex;
      logic ifgAdjust;
   } mtfs_tx_cfg_type;

   // Stored flow-control configuration
   typedef struct packed {
      logic txPauseEn;
      logic rxPauseEn;
   } mtfs_fc_cfg_type;

   // Controls presented to the transmitter datapath
   typedef struct packed {
      logic        txReset;
      logic        frameLimitOn;
      logic [15:0] maxFrameLen;
      logic        fcsFromClient;
      logic        padAndFcs;
      logic        enable;
      logic        vlan;
      logic        halfDuplex;
      logic [7:0]  ifgGap;
   } mtfs_tx_ctrl_type;

endpackage

// File: hw/mtfs_speed_reg.sv
// Link speed register, untouched by any reset
`timescale 1ns/1ps

module mtfs_speed_reg #(
   parameter mtfs_pkg::mtfs_build_type BUILD = mtfs_pkg::BUILD_TRI
) (
   input  wire logic       clk,       // Management clock
   input  wire logic       wrEn,      // Write strobe for the speed word
   input  wire logic [1:0] wrCode,    // Code offered by the write
   output logic [1:0]      speedCode  // Current speed code
);

   typedef struct packed {
      logic [1:0] code;
   } mtfs_speed_state_type;

   // Power-up value per build
   function automatic logic [1:0] initCode(mtfs_pkg::mtfs_build_type b);
      logic [1:0] c;
      c = mtfs_pkg::SPEED_RST;
      if (b == mtfs_pkg::BUILD_LOW) begin
         c = mtfs_pkg::SPEED_LOW_RST;
      end
      return c;
   endfunction

   mtfs_speed_state_type st_q = '{code: initCode(BUILD)};
   mtfs_speed_state_type st_d;

   // Accept only the codes the build supports
   always_comb begin
      st_d = st_q;
      unique case (BUILD)
         mtfs_pkg::BUILD_GIG: begin
            st_d.code = mtfs_pkg::SPEED_1G;
         end
         mtfs_pkg::BUILD_LOW: begin
            if (wrEn && (wrCode == mtfs_pkg::SPEED_10M ||
                         wrCode == mtfs_pkg::SPEED_100M)) begin
               st_d.code = wrCode;
            end
         end
         default: begin
            if (wrEn && wrCode != 2'h3) begin
               st_d.code = wrCode;
            end
         end
      endcase
   end

   // No reset term at all
   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign speedCode = st_q.code;

endmodule

// File: hw/mtfs_mac_cfg.sv
// Transmitter, flow-control and speed configuration registers of the MAC
`timescale 1ns/1ps

module mtfs_mac_cfg #(
   parameter mtfs_pkg::mtfs_build_type BUILD = mtfs_pkg::BUILD_TRI
) (
   input  wire logic                        clk,           // Management clock
   input  wire logic                        rstn,          // Sync reset, low
   input  wire mtfs_pkg::mtfs_mgmt_req_type mgmtReq,       // Register request
   output logic [31:0]                      mgmtRdData,    // Read word
   output logic                             mgmtRdValid,   // Read data strobe
   input  wire logic                        pauseReq,      // Pause request
   input  wire logic                        txFrameStart,  // Frame start
   input  wire logic [7:0]                  txIfgDelay,    // Gap extension
   input  wire logic                        rxPauseActive, // Pause time runs
   output mtfs_pkg::mtfs_tx_ctrl_type       txCtrl,        // Tx controls
   output logic                             pauseSend,     // Send pause frame
   output logic                             txHoldOff,     // Stall transmitter
   output logic                             pauseToClient, // Pass pause up
   output logic [1:0]                       speedCode      // Link speed code
);

   // State of this module except the speed code, which u_speed holds
   typedef struct packed {
      mtfs_pkg::mtfs_tx_cfg_type tx;
      mtfs_pkg::mtfs_fc_cfg_type fc;
      logic                      txRstPulse;
      logic [7:0]                ifgGap;
      logic                      pauseSend;
      logic                      holdOff;
      logic                      pauseToClient;
      logic [31:0]               rdData;
      logic                      rdValid;
   } mtfs_cfg_state_type;

   mtfs_cfg_state_type st_q;
   mtfs_cfg_state_type st_d;

   logic       speedWr;
   logic [1:0] speedNow;

   // Default transmitter fields, used at reset and on the self-clearing reset
   function automatic mtfs_pkg::mtfs_tx_cfg_type txDefault();
      mtfs_pkg::mtfs_tx_cfg_type c;
      c.jumbo         = mtfs_pkg::TX_JUMBO_RST;
      c.fcsFromClient = mtfs_pkg::TX_FCS_RST;
      c.enable        = mtfs_pkg::TX_EN_RST;
      c.vlan          = mtfs_pkg::TX_VLAN_RST;
      c.halfDuplex    = mtfs_pkg::TX_HD_RST;
      c.ifgAdjust     = mtfs_pkg::TX_IFG_RST;
      return c;
   endfunction

   // Default flow-control fields
   function automatic mtfs_pkg::mtfs_fc_cfg_type fcDefault();
      mtfs_pkg::mtfs_fc_cfg_type c;
      c.txPauseEn = mtfs_pkg::FC_TX_RST;
      c.rxPauseEn = mtfs_pkg::FC_RX_RST;
      return c;
   endfunction

   // Gap length chosen when a frame starts
   function automatic logic [7:0] gapFor(logic adjust, logic [7:0] delay);
      logic [7:0] g;
      g = mtfs_pkg::IFG_MIN_CYCLES;
      if (adjust && delay > mtfs_pkg::IFG_MIN_CYCLES) begin
         g = delay;
      end
      return g;
   endfunction

   // Transmitter word as seen by a read; reset bit always reads zero
   function automatic logic [31:0] txWord(mtfs_pkg::mtfs_tx_cfg_type c);
      logic [31:0] w;
      w = 32'h0;
      w[mtfs_pkg::TX_JUMBO_BIT] = c.jumbo;
      w[mtfs_pkg::TX_FCS_BIT]   = c.fcsFromClient;
      w[mtfs_pkg::TX_EN_BIT]    = c.enable;
      w[mtfs_pkg::TX_VLAN_BIT]  = c.vlan;
      w[mtfs_pkg::TX_HD_BIT]    = c.halfDuplex;
      w[mtfs_pkg::TX_IFG_BIT]   = c.ifgAdjust;
      return w;
   endfunction

   // Flow-control word as seen by a read
   function automatic logic [31:0] fcWord(mtfs_pkg::mtfs_fc_cfg_type c);
      logic [31:0] w;
      w = 32'h0;
      w[mtfs_pkg::FC_TX_BIT] = c.txPauseEn;
      w[mtfs_pkg::FC_RX_BIT] = c.rxPauseEn;
      return w;
   endfunction

   // Speed word as seen by a read
   function automatic logic [31:0] speedWord(logic [1:0] code);
      logic [31:0] w;
      w = 32'h0;
      w[mtfs_pkg::SPEED_LSB +: 2] = code;
      return w;
   endfunction

   // Request qualifier: a selected access of the given direction
   function automatic logic reqIs(mtfs_pkg::mtfs_mgmt_req_type r,
                                  logic wr);
      logic h;
      h = r.sel && (r.wr == wr);
      return h;
   endfunction

   // Speed register sits apart because no reset may touch it
   assign speedWr = reqIs(mgmtReq, 1'h1) &&
                    mgmtReq.addr == mtfs_pkg::SPEED_OFFSET;

   mtfs_speed_reg #(
      .BUILD (BUILD)
   ) u_speed (
      .clk       (clk),
      .wrEn      (speedWr),
      .wrCode    (mgmtReq.wdata[mtfs_pkg::SPEED_LSB +: 2]),
      .speedCode (speedNow)
   );

   // Next state: register writes, reads and flow-control gating
   always_comb begin
      st_d = st_q;
      st_d.txRstPulse = 1'h0;
      st_d.rdValid    = 1'h0;

      // Register writes; only documented fields are stored
      if (reqIs(mgmtReq, 1'h1)) begin
         unique case (mgmtReq.addr)
            mtfs_pkg::TX_CFG_OFFSET: begin
               if (mgmtReq.wdata[mtfs_pkg::TX_RESET_BIT]) begin
                  st_d.tx         = txDefault();
                  st_d.txRstPulse = 1'h1;
               end else begin
                  st_d.tx.jumbo =
                     mgmtReq.wdata[mtfs_pkg::TX_JUMBO_BIT];
                  st_d.tx.fcsFromClient =
                     mgmtReq.wdata[mtfs_pkg::TX_FCS_BIT];
                  st_d.tx.enable =
                     mgmtReq.wdata[mtfs_pkg::TX_EN_BIT];
                  st_d.tx.vlan =
                     mgmtReq.wdata[mtfs_pkg::TX_VLAN_BIT];
                  st_d.tx.halfDuplex =
                     mgmtReq.wdata[mtfs_pkg::TX_HD_BIT];
                  st_d.tx.ifgAdjust =
                     mgmtReq.wdata[mtfs_pkg::TX_IFG_BIT];
               end
            end
            mtfs_pkg::FC_CFG_OFFSET: begin
               st_d.fc.txPauseEn =
                  mgmtReq.wdata[mtfs_pkg::FC_TX_BIT];
               st_d.fc.rxPauseEn =
                  mgmtReq.wdata[mtfs_pkg::FC_RX_BIT];
            end
            default: begin
               // Other offsets and reserved bits are dropped
               st_d.rdData = st_q.rdData;
            end
         endcase
      end

      // Register reads; answer one cycle later, zero when unmapped
      if (reqIs(mgmtReq, 1'h0)) begin
         st_d.rdValid = 1'h1;
         unique case (mgmtReq.addr)
            mtfs_pkg::TX_CFG_OFFSET: begin
               st_d.rdData = txWord(st_q.tx);
            end
            mtfs_pkg::FC_CFG_OFFSET: begin
               st_d.rdData = fcWord(st_q.fc);
            end
            mtfs_pkg::SPEED_OFFSET: begin
               st_d.rdData = speedWord(speedNow);
            end
            default: begin
               st_d.rdData = 32'h0;
            end
         endcase
      end

      // Gap after each frame, caught as the frame starts
      if (!st_q.tx.ifgAdjust) begin
         st_d.ifgGap = mtfs_pkg::IFG_MIN_CYCLES;
      end else if (txFrameStart) begin
         st_d.ifgGap = gapFor(st_q.tx.ifgAdjust, txIfgDelay);
      end

      // Pause request passes only while transmit flow control is on
      st_d.pauseSend = pauseReq && st_q.fc.txPauseEn;

      // Received pause stalls the transmitter only when enabled
      st_d.holdOff = rxPauseActive && st_q.fc.rxPauseEn;

      // With receive flow control off, pause frames go up to the client
      st_d.pauseToClient = !st_q.fc.rxPauseEn;

      // Self-clearing reset also restarts the gap at its minimum
      if (st_d.txRstPulse) begin
         st_d.ifgGap = mtfs_pkg::IFG_MIN_CYCLES;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q.tx            <= txDefault();
         st_q.fc            <= fcDefault();
         st_q.txRstPulse    <= 1'h0;
         st_q.ifgGap        <= mtfs_pkg::IFG_MIN_CYCLES;
         st_q.pauseSend     <= 1'h0;
         st_q.holdOff       <= 1'h0;
         st_q.pauseToClient <= 1'h0;
         st_q.rdData        <= 32'h0;
         st_q.rdValid       <= 1'h0;
      end else begin
         st_q <= st_d;
      end
   end

   // Management answer
   assign mgmtRdData  = st_q.rdData;
   assign mgmtRdValid = st_q.rdValid;

   // Transmitter controls; one process drives the whole struct
   always_comb begin
      // Frame length limit is off in jumbo mode; its length follows the tagging choice
      txCtrl.frameLimitOn = !st_q.tx.jumbo;
      txCtrl.maxFrameLen  = st_q.tx.vlan ? mtfs_pkg::MAX_VLAN_LEN
                                         : mtfs_pkg::MAX_STD_LEN;
      // Check sequence source: client or own generator with padding
      txCtrl.fcsFromClient = st_q.tx.fcsFromClient;
      txCtrl.padAndFcs     = !st_q.tx.fcsFromClient;
      // Remaining transmitter controls
      txCtrl.txReset    = st_q.txRstPulse;
      txCtrl.enable     = st_q.tx.enable;
      txCtrl.vlan       = st_q.tx.vlan;
      txCtrl.halfDuplex = st_q.tx.halfDuplex;
      txCtrl.ifgGap     = st_q.ifgGap;
   end

   // Flow-control outputs
   assign pauseSend     = st_q.pauseSend;
   assign txHoldOff     = st_q.holdOff;
   assign pauseToClient = st_q.pauseToClient;

   // Speed code to the datapath
   assign speedCode = speedNow;

endmodule

// File: verif/mtfs_mac_cfg_monitor.sv
// Port checker for the MAC configuration registers
`timescale 1ns/1ps

module mtfs_mac_cfg_monitor #(
   parameter mtfs_pkg::mtfs_build_type BUILD = mtfs_pkg::BUILD_TRI
) (
   input wire logic                        clk,           // Clock
   input wire logic                        rstn,          // Reset
   input wire mtfs_pkg::mtfs_mgmt_req_type mgmtReq,       // Request
   input wire logic [31:0]                 mgmtRdData,    // Read word
   input wire logic                        mgmtRdValid,   // Read strobe
   input wire logic                        pauseReq,      // Pause ask
   input wire logic                        txFrameStart,  // Frame start
   input wire logic [7:0]                  txIfgDelay,    // Gap value
   input wire logic                        rxPauseActive, // Pause runs
   input wire mtfs_pkg::mtfs_tx_ctrl_type  txCtrl,        // Tx controls
   input wire logic                        pauseSend,     // Pause out
   input wire logic                        txHoldOff,     // Stall
   input wire logic                        pauseToClient, // Pass up
   input wire logic [1:0]                  speedCode      // Speed
);
   logic        fcTx_q;
   logic        fcRx_q;
   logic [31:0] wd_q;
   logic        fcWr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Flow bits as the writes left them
   assign fcWr = mgmtReq.sel && mgmtReq.wr
                 && mgmtReq.addr == mtfs_pkg::FC_CFG_OFFSET;
   always_ff @(posedge clk) begin
      wd_q <= mgmtReq.wdata;
      if (!rstn) begin
         fcTx_q <= 1'h1;
         fcRx_q <= 1'h1;
      end else if (fcWr) begin
         fcTx_q <= mgmtReq.wdata[30];
         fcRx_q <= mgmtReq.wdata[29];
      end
   end

   // Accesses to the transmitter word
   sequence txAcc;
      mgmtReq.sel && mgmtReq.addr == mtfs_pkg::TX_CFG_OFFSET;
   endsequence
   sequence txRst;
      txAcc ##0 mgmtReq.wr && mgmtReq.wdata[31];
   endsequence
   sequence txSet;
      txAcc ##0 mgmtReq.wr && !mgmtReq.wdata[31];
   endsequence

   tx_reset_pulse_a:
   assert property (txRst |=> txCtrl.txReset)
      else $error("transmitter reset pulse missing");
   tx_defaults_a:
   assert property (txCtrl.txReset |-> txCtrl.enable && !txCtrl.vlan
      && !txCtrl.halfDuplex && !txCtrl.fcsFromClient && txCtrl.frameLimitOn)
      else $error("transmitter fields not default on reset");
   tx_fields_a:
   assert property (txSet |=> txCtrl.enable == wd_q[28]
      && txCtrl.vlan == wd_q[27] && txCtrl.halfDuplex == wd_q[26]
      && txCtrl.fcsFromClient == wd_q[29] && txCtrl.frameLimitOn != wd_q[30])
      else $error("transmitter fields differ from write");
   frame_shape_a:
   assert property (txCtrl.padAndFcs != txCtrl.fcsFromClient
      && txCtrl.maxFrameLen == (txCtrl.vlan ? mtfs_pkg::MAX_VLAN_LEN
                                            : mtfs_pkg::MAX_STD_LEN))
      else $error("pad or frame length wrong");
   tx_readback_a:
   assert property (txAcc ##0 !mgmtReq.wr |=> mgmtRdValid
      && !mgmtRdData[31] && mgmtRdData[24:0] == 25'h0)
      else $error("transmitter word read wrong");
   pause_send_a:
   assert property ($past(rstn) |-> pauseSend == ($past(pauseReq)
      && $past(fcTx_q)))
      else $error("pause send mismatch");
   hold_off_a:
   assert property ($past(rstn) |-> txHoldOff == ($past(rxPauseActive)
      && $past(fcRx_q)))
      else $error("hold off mismatch");
   gap_floor_a:
   assert property (txCtrl.ifgGap >= mtfs_pkg::IFG_MIN_CYCLES)
      else $error("gap below minimum");
   speed_keep_a:
   assert property (disable iff (1'b0)
      !rstn && !mgmtReq.sel |=> $stable(speedCode))
      else $error("speed changed by reset");
   speed_legal_a:
   assert property (speedCode != 2'h3
      && (BUILD != mtfs_pkg::BUILD_GIG || speedCode == mtfs_pkg::SPEED_1G)
      && (BUILD != mtfs_pkg::BUILD_LOW || !speedCode[1]))
      else $error("speed code illegal");
endmodule

bind mtfs_mac_cfg mtfs_mac_cfg_monitor #(.BUILD(BUILD)) mon (
   .clk(clk), .rstn(rstn), .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData),
   .mgmtRdValid(mgmtRdValid), .pauseReq(pauseReq),
   .txFrameStart(txFrameStart), .txIfgDelay(txIfgDelay),
   .rxPauseActive(rxPauseActive), .txCtrl(txCtrl), .pauseSend(pauseSend),
   .txHoldOff(txHoldOff), .pauseToClient(pauseToClient),
   .speedCode(speedCode)
);

// File: verif/mtfs_host_model.sv
// Host processor model issuing register accesses
`timescale 1ns/1ps

module mtfs_host_model (
   input  wire logic                  clk,    // Clock
   output mtfs_pkg::mtfs_mgmt_req_type req,   // Request
   input  wire logic [31:0]           rdData, // Read word
   input  wire logic                  rdValid // Read strobe
);
   // Idle bus
   initial req = '0;

   // One access held to its taking edge, then idle with inverted leftovers
   task automatic access(input logic w, input logic [11:0] a,
                         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      req <= '{sel: 1'h1, wr: w, addr: a, wdata: d};
      @(posedge clk);
      req <= '{sel: 1'h0, wr: ~w, addr: ~a, wdata: ~d};
      #1;
      q = (w || rdValid === 1'h1) ? rdData : 'x;
   endtask
endmodule

// File: verif/mtfs_mac_cfg_tb_top.sv
// Self-checking bench for the MAC configuration registers
`timescale 1ns/1ps

module mtfs_mac_cfg_tb_top;
   localparam logic [11:0] TXA = mtfs_pkg::TX_CFG_OFFSET;
   localparam logic [11:0] FCA = mtfs_pkg::FC_CFG_OFFSET;
   localparam logic [11:0] SPA = mtfs_pkg::SPEED_OFFSET;
   logic                        clk;
   logic                        rstn;
   mtfs_pkg::mtfs_mgmt_req_type mgmtReq;
   logic [31:0]                 mgmtRdData;
   logic                        mgmtRdValid;
   logic                        pauseReq;
   logic                        txFrameStart;
   logic [7:0]                  txIfgDelay;
   logic                        rxPauseActive;
   mtfs_pkg::mtfs_tx_ctrl_type  txCtrl;
   logic                        pauseSend;
   logic                        txHoldOff;
   logic                        pauseToClient;
   logic [1:0]                  speedCode;
   logic [1:0]                  speedGig;
   logic [1:0]                  speedLow;
   int                          errorCnt;
   int                          nChecks;

   mtfs_mac_cfg dut (.clk(clk), .rstn(rstn), .mgmtReq(mgmtReq),
      .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
      .pauseReq(pauseReq), .txFrameStart(txFrameStart),
      .txIfgDelay(txIfgDelay), .rxPauseActive(rxPauseActive),
      .txCtrl(txCtrl), .pauseSend(pauseSend), .txHoldOff(txHoldOff),
      .pauseToClient(pauseToClient), .speedCode(speedCode));
   mtfs_host_model host (.clk(clk), .req(mgmtReq), .rdData(mgmtRdData),
      .rdValid(mgmtRdValid));

   // Gigabit-only and low-speed builds share the bus; their speed codes are watched
   mtfs_mac_cfg #(.BUILD(mtfs_pkg::BUILD_GIG)) dutGig (.clk(clk),
      .rstn(rstn), .mgmtReq(mgmtReq), .mgmtRdData(), .mgmtRdValid(),
      .pauseReq(pauseReq), .txFrameStart(txFrameStart),
      .txIfgDelay(txIfgDelay), .rxPauseActive(rxPauseActive),
      .txCtrl(), .pauseSend(), .txHoldOff(), .pauseToClient(),
      .speedCode(speedGig));
   mtfs_mac_cfg #(.BUILD(mtfs_pkg::BUILD_LOW)) dutLow (.clk(clk),
      .rstn(rstn), .mgmtReq(mgmtReq), .mgmtRdData(), .mgmtRdValid(),
      .pauseReq(pauseReq), .txFrameStart(txFrameStart),
      .txIfgDelay(txIfgDelay), .rxPauseActive(rxPauseActive),
      .txCtrl(), .pauseSend(), .txHoldOff(), .pauseToClient(),
      .speedCode(speedLow));

   // 25 MHz clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      nChecks++;
      if (g !== e) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.access(1'h1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      host.access(1'h0, a, 32'h0, q);
      chk("readWord", e, q);
   endtask

   function automatic logic [31:0] txBits();
      return {26'h0, txCtrl.enable, txCtrl.vlan, txCtrl.halfDuplex,
              txCtrl.fcsFromClient, txCtrl.padAndFcs, txCtrl.frameLimitOn};
   endfunction

   // Power-up words and an unmapped read
   task automatic t_defaults;
      rd(TXA, 32'h10000000);
      rd(FCA, 32'h60000000);
      rd(SPA, 32'h80000000);
      chk("speedGig", 32'h2, {30'h0, speedGig});
      chk("speedLow", 32'h1, {30'h0, speedLow});
      rd(12'h414, 32'h00000000);
   endtask

   // All transmitter fields set, then the self-clearing reset
   task automatic t_txword;
      wr(TXA, 32'h7fffffff);
      chk("txFields", 32'h3c, txBits());
      chk("maxLen", 32'h5f2, {16'h0, txCtrl.maxFrameLen});
      rd(TXA, 32'h7e000000);
      wr(TXA, 32'h80000000);
      chk("txReset", 32'h1, {31'h0, txCtrl.txReset});
      chk("txFields", 32'h23, txBits());
      chk("maxLen", 32'h5ee, {16'h0, txCtrl.maxFrameLen});
      rd(TXA, 32'h10000000);
      chk("txReset", 32'h0, {31'h0, txCtrl.txReset});
      wr(TXA, 32'h00000000);
      chk("txFields", 32'h03, txBits());
      wr(TXA, 32'h10000000);
   endtask

   task automatic pulsePause(input logic e);
      @(posedge clk);
      pauseReq <= 1'h1;
      @(posedge clk);
      pauseReq <= 1'h0;
      #1;
      chk("pauseSend", {31'h0, e}, {31'h0, pauseSend});
   endtask

   task automatic holdOff(input logic e);
      @(posedge clk);
      rxPauseActive <= 1'h1;
      @(posedge clk);
      rxPauseActive <= 1'h0;
      #1;
      chk("txHoldOff", {31'h0, e}, {31'h0, txHoldOff});
      chk("pauseToClient", {31'h0, ~e}, {31'h0, pauseToClient});
   endtask

   // Pause request and received pause, each way of the flow bits
   task automatic t_pause;
      pulsePause(1'h1);
      holdOff(1'h1);
      wr(FCA, 32'h00000000);
      pulsePause(1'h0);
      holdOff(1'h0);
      wr(FCA, 32'hffffffff);
      rd(FCA, 32'h60000000);
      pulsePause(1'h1);
   endtask

   task automatic gapStart(input logic [7:0] dly, input logic [7:0] e);
      @(posedge clk);
      txIfgDelay <= dly;
      txFrameStart <= 1'h1;
      @(posedge clk);
      txFrameStart <= 1'h0;
      #1;
      chk("ifgGap", {24'h0, e}, {24'h0, txCtrl.ifgGap});
   endtask

   // Gap extension on and off
   task automatic t_gap;
      wr(TXA, 32'h12000000);
      gapStart(8'h20, 8'h20);
      gapStart(8'h05, 8'h0c);
      wr(TXA, 32'h10000000);
      gapStart(8'h30, 8'h0c);
   endtask

   // Every speed code, then a reset that must leave it alone
   task automatic t_speed;
      logic [1:0] e;
      logic [1:0] lo;
      for (int c = 0; c < 4; c++) begin
         e = (c == 3) ? 2'h2 : 2'(c);
         lo = (c == 0) ? 2'h0 : 2'h1;
         wr(SPA, {2'(c), 30'h3fffffff});
         rd(SPA, {e, 30'h0});
         chk("speedGig", 32'h2, {30'h0, speedGig});
         chk("speedLow", {30'h0, lo}, {30'h0, speedLow});
      end
      wr(SPA, 32'h40000000);
      @(posedge clk);
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      #1;
      chk("speedCode", 32'h1, {30'h0, speedCode});
      chk("speedGig", 32'h2, {30'h0, speedGig});
      chk("speedLow", 32'h1, {30'h0, speedLow});
      rd(SPA, 32'h40000000);
   endtask

   task automatic testDone;
      $display("checks %0d errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence
   initial begin
      errorCnt = 0;
      nChecks = 0;
      rstn = 1'h0;
      pauseReq = 1'h0;
      txFrameStart = 1'h0;
      txIfgDelay = 8'h00;
      rxPauseActive = 1'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      t_defaults();
      t_txword();
      t_pause();
      t_gap();
      t_speed();
      testDone();
   end

   // Hang guard
   initial begin
      repeat (4000) @(posedge clk);
      errorCnt++;
      testDone();
   end
endmodule
